// file: rtl/core_defs.svh
// Purpose: Shared constants for the core flags and operand decode
// Assumes: One clk edge per oscillator period
// Notes: Definitions only
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

// Flags register location and power-on value
`define FLAGS_ADDR 5'h03
`define FLAGS_RESET 8'h18

// Flag bit positions
`define BIT_SPARE 7
`define BIT_PAGE_HI 6
`define BIT_PAGE_LO 5
`define BIT_TIMEOUT 4
`define BIT_SLEEP 3
`define BIT_ZERO 2
`define BIT_NIBBLE 1
`define BIT_CARRY 0

// Timing
`define OSC_PER_CYCLE 4
`define PAGE_WORDS 512

// Fixed control encodings
`define OP_SLEEP 12'h003
`define OP_KICK 12'h004
`define JUMP_OPC 3'h5

`endif

// file: rtl/core_pkg.sv
// Purpose: Types for the core flags and operand decode
// Assumes: Nothing
// Notes: Phase codes are Gray along the cycle
package core_pkg;

	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_t;

	typedef enum logic [1:0] {
		CLS_BYTE = 2'h0,
		CLS_BIT = 2'h1,
		CLS_LIT = 2'h2,
		CLS_JUMP = 2'h3
	} op_class_t;

endpackage

// file: rtl/decode_if.sv
// Purpose: Carries an instruction word and its decoded fields
// Assumes: Decoder is purely combinational
// Notes: One modport per side
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
	import core_pkg::*;
	logic [11:0] word;
	op_class_t op_class;
	logic [5:0] opcode;
	logic [4:0] file_addr;
	logic dest_file;
	logic [2:0] bit_sel;
	logic [8:0] literal;
	logic is_jump;
	logic is_sleep;
	logic is_kick;
	modport decoder (input word, output op_class, opcode, file_addr, dest_file, bit_sel, literal, is_jump,
		is_sleep, is_kick);
	modport core (output word, input op_class, opcode, file_addr, dest_file, bit_sel, literal, is_jump,
		is_sleep, is_kick);
endinterface
`default_nettype wire

// file: rtl/operand_decoder.sv
// Purpose: Splits a 12-bit word into class, opcode and operands
// Assumes: Word is stable for the whole cycle
// Notes: Combinational
`timescale 1ns/10ps
`default_nettype none
`include "core_defs.svh"
module operand_decoder
	import core_pkg::*;
(
	// Word and fields
	decode_if.decoder dif
);
	always_comb begin
		dif.is_jump = (dif.word[11:9] == `JUMP_OPC);
		if (dif.word[11:10] == 2'b00) begin
			dif.op_class = CLS_BYTE;
			dif.opcode = dif.word[11:6];
		end else if (dif.word[11:10] == 2'b01) begin
			dif.op_class = CLS_BIT;
			dif.opcode = {dif.word[11:8], 2'b00};
		end else if (dif.is_jump) begin
			dif.op_class = CLS_JUMP;
			dif.opcode = {dif.word[11:9], 3'h0};
		end else begin
			dif.op_class = CLS_LIT;
			dif.opcode = {dif.word[11:8], 2'b00};
		end
		dif.file_addr = dif.word[4:0];
		dif.bit_sel = dif.word[7:5];
		dif.dest_file = (dif.op_class == CLS_BYTE) ? dif.word[5] : (dif.op_class == CLS_BIT);
		dif.literal = dif.is_jump ? dif.word[8:0] : {1'b0, dif.word[7:0]};
		dif.is_sleep = (dif.word == `OP_SLEEP);
		dif.is_kick = (dif.word == `OP_KICK);
	end
endmodule
`default_nettype wire

// file: rtl/page_mapper.sv
// Purpose: Builds program addresses from the page preselect bits
// Assumes: Pages of equal size
// Notes: Combinational
`timescale 1ns/10ps
`default_nettype none
module page_mapper #(
	parameter int PAGE_BITS = 2,
	parameter int OFFSET_BITS = 9
) (
	// Page and target
	input wire logic [PAGE_BITS-1:0] page_preselect,
	input wire logic [OFFSET_BITS-1:0] target,
	// Addresses
	output logic [PAGE_BITS+OFFSET_BITS-1:0] page_base,
	output logic [PAGE_BITS+OFFSET_BITS-1:0] jump_addr
);
	always_comb begin
		page_base = {page_preselect, {OFFSET_BITS{1'b0}}};
		jump_addr = {page_preselect, target};
	end
endmodule
`default_nettype wire

// file: rtl/core_status_decode.sv
// Purpose: Core flags register, cycle sequencing and operand decode
// Assumes: clk is the oscillator; datapath results valid in the last phase
// Notes: Undefined arithmetic flags come up as zero
`timescale 1ns/10ps
`default_nettype none
`include "core_defs.svh"
// Behaviour
// - Flag-affecting ops writing the flags keep the operation's zero, nibble, carry.
// - Instruction writes never change the timeout or sleep flag bits.
// - Flags at file address 03h; reset gives upper zero, timeout and sleep one.
// - Sleep flag set at power-up or kick, cleared by sleep instruction.
// - Each 12-bit word is decoded into byte, bit, literal or jump classes.
// - File number selects one of 32 registers, 0x00 to 0x1F.
// - Destination bit zero sends result to accumulator, one to the file.
// - Bit select picks one of eight bit positions.
// - Literal operand is 8 or 9 bits, passed to datapath or counter.
// - Don't-care bits have no effect on decoding.
// - Byte words: opcode 11:6, dest 5, file 4:0; bit select in 7:5.
// - Jump uses 11:9 opcode, 9-bit target; other literals 11:8 and 7:0.
// - An instruction cycle is four oscillator periods.
// - One cycle per instruction, two when a skip or counter change occurs.
module core_status_decode
	import core_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Program memory
	input wire logic [11:0] instr_word,
	input wire logic instr_valid,
	// Datapath results
	input wire logic file_write,
	input wire logic [7:0] write_data,
	input wire logic [7:0] result_data,
	input wire logic result_nibble_carry,
	input wire logic result_carry,
	input wire logic affects_zero,
	input wire logic affects_nibble,
	input wire logic affects_carry,
	input wire logic pc_change,
	input wire logic skip_taken,
	// Watchdog
	input wire logic wdt_timeout,
	// Flags
	output logic [7:0] core_flags_register,
	// Decoded operands
	output op_class_t op_class,
	output logic [5:0] opcode,
	output logic [4:0] file_addr,
	output logic dest_file,
	output logic [2:0] bit_sel,
	output logic [8:0] literal,
	output logic [10:0] jump_addr,
	output logic [10:0] page_base,
	// Sequencing
	output phase_t cycle_phase,
	output logic flush_cycle,
	output logic sleep_pulse,
	output logic kick_pulse
);
	decode_if dec ();

	phase_t phase_reg, phase_next;
	logic [11:0] word_reg, word_next;
	logic valid_reg, valid_next;
	logic flush_reg, flush_next;
	logic [7:0] flags_reg, flags_next;
	op_class_t class_reg;
	logic [5:0] opcode_reg;
	logic [4:0] file_reg;
	logic dest_reg;
	logic [2:0] bit_reg;
	logic [8:0] literal_reg;
	logic [10:0] jump_reg, jump_next;
	logic [10:0] base_reg, base_next;
	logic sleep_reg, sleep_next;
	logic kick_reg, kick_next;
	logic exec;
	logic flags_write;

	assign dec.word = word_reg;

	operand_decoder u_decoder (
		.dif(dec)
	);

	page_mapper #(
		.PAGE_BITS(2),
		.OFFSET_BITS(9)
	) u_pages (
		.page_preselect(flags_reg[`BIT_PAGE_HI:`BIT_PAGE_LO]),
		.target(dec.literal),
		.page_base(base_next),
		.jump_addr(jump_next)
	);

	// Execute at last phase of a non-flush cycle
	assign exec = (phase_reg == PH_Q4) && valid_reg && !flush_reg;
	assign flags_write = file_write && dec.dest_file && (dec.file_addr == `FLAGS_ADDR);

	// Sequencer next state
	always_comb begin
		phase_next = phase_reg;
		word_next = word_reg;
		valid_next = valid_reg;
		flush_next = flush_reg;
		case (phase_reg)
			PH_Q1: phase_next = PH_Q2;
			PH_Q2: phase_next = PH_Q3;
			PH_Q3: phase_next = PH_Q4;
			default: phase_next = PH_Q1;
		endcase
		if (phase_reg == PH_Q4) begin
			word_next = instr_word;
			valid_next = instr_valid;
			flush_next = exec && (dec.is_jump || pc_change || skip_taken);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			phase_reg <= PH_Q1;
			word_reg <= 12'h000;
			valid_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			word_reg <= word_next;
			valid_reg <= valid_next;
			flush_reg <= flush_next;
		end
	end

	// Flags next state
	always_comb begin
		flags_next = flags_reg;
		sleep_next = 1'b0;
		kick_next = 1'b0;
		if (exec) begin
			if (flags_write) begin
				flags_next[`BIT_SPARE:`BIT_PAGE_LO] = write_data[`BIT_SPARE:`BIT_PAGE_LO];
				// write blocked where operation owns flag
				if (!affects_zero) begin
					flags_next[`BIT_ZERO] = write_data[`BIT_ZERO];
				end
				if (!affects_nibble) begin
					flags_next[`BIT_NIBBLE] = write_data[`BIT_NIBBLE];
				end
				if (!affects_carry) begin
					flags_next[`BIT_CARRY] = write_data[`BIT_CARRY];
				end
				// timeout and sleep bits untouched here
			end
			if (affects_zero) begin
				flags_next[`BIT_ZERO] = (result_data == 8'h00);
			end
			if (affects_nibble) begin
				flags_next[`BIT_NIBBLE] = result_nibble_carry;
			end
			if (affects_carry) begin
				flags_next[`BIT_CARRY] = result_carry;
			end
			if (dec.is_kick) begin
				flags_next[`BIT_TIMEOUT] = 1'b1;
				flags_next[`BIT_SLEEP] = 1'b1;
				kick_next = 1'b1;
			end
			if (dec.is_sleep) begin
				flags_next[`BIT_TIMEOUT] = 1'b1;
				flags_next[`BIT_SLEEP] = 1'b0;
				sleep_next = 1'b1;
			end
		end
		if (wdt_timeout) begin
			flags_next[`BIT_TIMEOUT] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flags_reg <= `FLAGS_RESET;
			sleep_reg <= 1'b0;
			kick_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			sleep_reg <= sleep_next;
			kick_reg <= kick_next;
		end
	end

	// Registered decode outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			class_reg <= CLS_BYTE;
			opcode_reg <= 6'h00;
			file_reg <= 5'h00;
			dest_reg <= 1'b0;
			bit_reg <= 3'h0;
			literal_reg <= 9'h000;
			jump_reg <= 11'h000;
			base_reg <= 11'h000;
		end else begin
			class_reg <= dec.op_class;
			opcode_reg <= dec.opcode;
			file_reg <= dec.file_addr;
			dest_reg <= dec.dest_file;
			bit_reg <= dec.bit_sel;
			literal_reg <= dec.literal;
			jump_reg <= jump_next;
			base_reg <= base_next;
		end
	end

	assign core_flags_register = flags_reg;
	assign op_class = class_reg;
	assign opcode = opcode_reg;
	assign file_addr = file_reg;
	assign dest_file = dest_reg;
	assign bit_sel = bit_reg;
	assign literal = literal_reg;
	assign jump_addr = jump_reg;
	assign page_base = base_reg;
	assign cycle_phase = phase_reg;
	assign flush_cycle = flush_reg;
	assign sleep_pulse = sleep_reg;
	assign kick_pulse = kick_reg;

	// Checks
	reset_values_a: assert property (@(posedge clk) $past(reset) && !reset |->
		flags_reg[7:3] == 5'b00011) else $error("flags wrong after reset");

	ro_bits_a: assert property (@(posedge clk) disable iff (reset)
		exec && flags_write && !dec.is_kick && !dec.is_sleep && !wdt_timeout
		|=> flags_reg[4:3] == $past(flags_reg[4:3])) else $error("timeout or sleep bit written");

	arith_keep_a: assert property (@(posedge clk) disable iff (reset)
		exec && flags_write && affects_carry |=> flags_reg[0] == $past(result_carry))
		else $error("carry taken from write data");

	zero_flag_a: assert property (@(posedge clk) disable iff (reset)
		exec && affects_zero |=> flags_reg[2] == ($past(result_data) == 8'h00))
		else $error("zero flag mismatch");

	sleep_clear_a: assert property (@(posedge clk) disable iff (reset)
		exec && dec.is_sleep && !wdt_timeout |=> !flags_reg[3] && flags_reg[4] && sleep_pulse)
		else $error("sleep did not update flags");

	kick_set_a: assert property (@(posedge clk) disable iff (reset)
		exec && dec.is_kick && !wdt_timeout |=> flags_reg[4:3] == 2'b11 && kick_pulse)
		else $error("kick did not set flags");

	wdt_clear_a: assert property (@(posedge clk) disable iff (reset)
		wdt_timeout |=> !flags_reg[4]) else $error("timeout flag not cleared");

	phase_order_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q1 |=> phase_reg == PH_Q2 ##1 phase_reg == PH_Q3 ##1 phase_reg == PH_Q4
		##1 phase_reg == PH_Q1) else $error("phase order broken");

	jump_flush_a: assert property (@(posedge clk) disable iff (reset)
		exec && dec.is_jump |=> flush_reg [*4] ##1 !flush_reg) else $error("jump not two cycles");

	plain_single_a: assert property (@(posedge clk) disable iff (reset)
		exec && !dec.is_jump && !pc_change && !skip_taken |=> !flush_reg)
		else $error("unexpected second cycle");

	byte_fields_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && $past(phase_reg) == PH_Q2 && class_reg == CLS_BYTE
		|-> file_addr == word_reg[4:0] && opcode == word_reg[11:6] && dest_file == word_reg[5])
		else $error("byte fields wrong");

	bit_field_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 |-> bit_sel == word_reg[7:5]) else $error("bit select wrong");

	class_decode_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11:10] == 2'b01 |-> class_reg == CLS_BIT)
		else $error("class wrong");

	jump_target_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11:9] == 3'h5 && $stable(flags_reg[6:5])
		|-> jump_addr == {flags_reg[6:5], word_reg[8:0]} && page_base[8:0] == 9'h000)
		else $error("jump address wrong");

	literal_field_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11:10] == 2'b11 |-> literal == {1'b0, word_reg[7:0]})
		else $error("literal wrong");

	file_number_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && !word_reg[11] |-> file_addr == word_reg[4:0])
		else $error("file number wrong");

	dest_select_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11:10] == 2'b00 |-> dest_file == word_reg[5])
		else $error("destination wrong");

	jump_literal_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11:9] == `JUMP_OPC |-> literal == word_reg[8:0])
		else $error("jump literal wrong");

	opcode_pad_a: assert property (@(posedge clk) disable iff (reset)
		phase_reg == PH_Q3 && word_reg[11] |-> opcode[1:0] == 2'b00)
		else $error("literal bits leak into opcode");

endmodule
`default_nettype wire

// file: sim/program_memory.sv
// Purpose: Program memory model feeding one word per instruction cycle
// Assumes: Word is sampled at the edge ending phase Q4
// Notes: Lines carry a changing pattern outside the fetch phase
`timescale 1ns/10ps
`default_nettype none
module program_memory
	import core_pkg::*;
(
	// Clock and phase
	input wire logic clk,
	input wire phase_t cycle_phase,
	// Next fetch
	input wire logic [11:0] next_word,
	input wire logic next_valid,
	// Fetch bus
	output logic [11:0] instr_word,
	output logic instr_valid
);
	initial begin
		instr_word = 12'h000;
		instr_valid = 1'b0;
	end
	always @(posedge clk) begin
		if (cycle_phase === PH_Q3) begin
			instr_word <= next_word;
			instr_valid <= next_valid;
		end else begin
			instr_word <= ~instr_word;
			instr_valid <= ~instr_valid;
		end
	end
endmodule
`default_nettype wire

// file: sim/test_core_status_and_operand_decode.sv
// Purpose: Self-checking bench for the core flags and operand decode
// Assumes: Datapath inputs set before the edge ending phase Q4
// Notes: Random instruction stream with a reset in mid-run
`timescale 1ns/10ps
`default_nettype none
module test_core_status_and_operand_decode
	import core_pkg::*;
;
	logic clk = 1'b0, reset = 1'b1, nv = 1'b0, fw = 1'b0, rn = 1'b0, rc = 1'b0;
	logic az = 1'b0, an = 1'b0, ac = 1'b0, pcc = 1'b0, sk = 1'b0, wdt = 1'b0;
	logic [11:0] nw = 12'h000, iw, hw;
	logic [7:0] wd = 8'h00, rd = 8'h00, flags, ef;
	logic iv, hv, fl, ex, nf, sx, kx, df, fl_o, sp, kp;
	op_class_t cls;
	logic [5:0] opc;
	logic [4:0] fa;
	logic [2:0] bs;
	logic [8:0] lit, le;
	logic [10:0] ja, pb;
	phase_t ph;
	logic [31:0] r, q;
	int miscompares = 0, total_checks = 0, cycles = 0;
	integer seed = 32'h7baff578;

	always #20 clk = ~clk;

	program_memory program_memory_inst (.clk(clk), .cycle_phase(ph), .next_word(nw), .next_valid(nv),
		.instr_word(iw), .instr_valid(iv));
	core_status_decode core_status_decode_inst (.clk(clk), .reset(reset), .instr_word(iw), .instr_valid(iv),
		.file_write(fw), .write_data(wd), .result_data(rd), .result_nibble_carry(rn), .result_carry(rc),
		.affects_zero(az), .affects_nibble(an), .affects_carry(ac), .pc_change(pcc), .skip_taken(sk),
		.wdt_timeout(wdt), .core_flags_register(flags), .op_class(cls), .opcode(opc), .file_addr(fa),
		.dest_file(df), .bit_sel(bs), .literal(lit), .jump_addr(ja), .page_base(pb), .cycle_phase(ph),
		.flush_cycle(fl_o), .sleep_pulse(sp), .kick_pulse(kp));

	task automatic results;
		if (miscompares == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares = miscompares + 1;
			results;
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic do_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		ef = 8'h18;
		hv = 1'b0;
		fl = 1'b0;
		@(negedge clk);
		check("flags", flags, 8'h18);
		check("phase", ph, PH_Q1);
	endtask

	// Reference update at the execute edge
	task automatic model;
		logic tgt;
		ex = hv && !fl;
		tgt = ((hw[11:10] == 2'h0 && hw[5]) || hw[11:10] == 2'h1) && hw[4:0] == 5'h03;
		if (ex) begin
			if (hw == 12'h003) ef[4:3] = 2'b10;
			if (hw == 12'h004) ef[4:3] = 2'b11;
			if (fw && tgt) begin
				ef[7:5] = wd[7:5];
				ef[2:0] = (wd[2:0] & ~{az, an, ac}) | (ef[2:0] & {az, an, ac});
			end
			if (az) ef[2] = rd == 8'h00;
			if (an) ef[1] = rn;
			if (ac) ef[0] = rc;
		end
		if (wdt) ef[4] = 1'b0;
		nf = ex && (hw[11:9] == 3'h5 || pcc || sk);
		sx = ex && hw == 12'h003;
		kx = ex && hw == 12'h004;
		hw = nw;
		hv = nv;
		fl = nf;
	endtask

	task automatic step;
		r = $random(seed);
		q = $random(seed);
		do @(posedge clk); while (ph !== PH_Q2);
		nw <= r[14:12] == 3'h0 ? 12'h003 : r[14:12] == 3'h1 ? 12'h004 :
			r[14:12] == 3'h2 ? {r[11:5], 5'h03} : r[11:0];
		nv <= r[15] | r[16];
		do @(posedge clk); while (ph !== PH_Q3);
		{fw, wd, rn, rc, az, an, ac} <= q[13:0];
		rd <= q[14] ? 8'h00 : q[22:15];
		pcc <= &q[24:23];
		sk <= &q[26:25];
		wdt <= q[31:28] == 4'h0;
		do @(posedge clk); while (ph !== PH_Q4);
		wdt <= 1'b0;
		model;
		@(negedge clk);
		check("phase", ph, PH_Q1);
		check("flags", flags, ef);
		check("flush", fl_o, fl);
		check("sleep pulse", sp, sx);
		check("kick pulse", kp, kx);
		@(negedge clk);
		check("sleep pulse end", sp, 1'b0);
		if (hv && !fl) begin
			le = hw[11:9] == 3'h5 ? hw[8:0] : {1'b0, hw[7:0]};
			check("class", cls, hw[11:10] == 2'h0 ? CLS_BYTE : hw[11:10] == 2'h1 ? CLS_BIT :
				hw[11:9] == 3'h5 ? CLS_JUMP : CLS_LIT);
			check("opcode", opc, hw[11:10] == 2'h0 ? hw[11:6] : hw[11:9] == 3'h5 ? {hw[11:9], 3'h0} :
				{hw[11:8], 2'h0});
			check("dest", df, hw[11:10] == 2'h0 ? hw[5] : hw[11:10] == 2'h1);
			if (!hw[11]) check("file", fa, hw[4:0]);
			if (hw[11:10] == 2'h1) check("bit", bs, hw[7:5]);
			check("literal", lit, le);
			check("jump addr", ja, {ef[6:5], le});
			check("page base", pb, ef[6:5] * 11'h200);
		end
	endtask

	initial begin
		do_reset;
		repeat (300) step;
		do_reset;
		repeat (100) step;
		results;
	end
endmodule
`default_nettype wire
